// ---- core/gpio_pad_control.sv ----
// pad control top: ahb-lite registers, seven pins and pad strength outputs
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module gpio_pad_control (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic radio_out_of_idle,
    input wire logic crc_cca_valid,
    input wire logic [6:0] pin_i,
    output logic [6:0] pin_o,
    output logic [6:0] pin_oe,
    output logic [6:0] pin_in_level,
    output logic [1:0] low_pins_drive_strength,
    output logic [1:0] high_pins_drive_strength,
    output logic [1:0] serial_out_drive_strength,
    output logic [1:0] clock_out_drive_strength,
    output logic [1:0] irq_drive_strength,
    output logic irq_pullup_enable
);
    // register state and bus phase tracking
    logic [15:0] dir_q;
    logic [15:0] dir_d;
    logic [15:0] out_q;
    logic [15:0] out_d;
    logic [15:0] alt_q;
    logic [15:0] alt_d;
    logic wr_pend_q;
    logic wr_pend_d;
    logic [9:0] wr_addr_q;
    logic [9:0] wr_addr_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic take;
    logic [6:0] pin_oe_en;
    logic [6:0] pin_ien;
    logic [6:0] pin_lvl;
    logic alt_en;

    // word-aligned byte address from a byte address; used by reads and writes
    function automatic logic [9:0] word_addr(input logic [31:0] a);
        word_addr = {a[9:2], 2'b00};
    endfunction : word_addr

    // a transfer is taken only in a nonseq address phase; hsize is ignored, all are words
    assign take = hsel & hready & (htrans == pad_ctrl_pkg::HTRANS_NONSEQ);
    // no wait states ever, every access answers okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // read data stands from a flop through the whole data phase
    assign hrdata = hrdata_q;

    // register next state: write lands in data phase, read data sampled in address phase
    always_comb
    begin
        dir_d = dir_q;
        out_d = out_q;
        alt_d = alt_q;
        wr_pend_d = take & hwrite;
        wr_addr_d = word_addr(haddr);
        hrdata_d = hrdata_q;
        // a read right behind a write to the same word still returns the old value
        if (wr_pend_q)
        begin
            if (wr_addr_q == pad_ctrl_pkg::DIR_ADDR)
                dir_d = hwdata[15:0];
            else if (wr_addr_q == pad_ctrl_pkg::OUT_ADDR)
                out_d = hwdata[15:0];
            else if (wr_addr_q == pad_ctrl_pkg::ALT_ADDR)
                alt_d = hwdata[15:0];
        end
        // read data is chosen from the registers as they stand in the address phase
        if (take & ~hwrite)
        begin
            // unmapped addresses read as zero
            if (word_addr(haddr) == pad_ctrl_pkg::DIR_ADDR)
                hrdata_d = {16'h0000, dir_q};
            else if (word_addr(haddr) == pad_ctrl_pkg::OUT_ADDR)
                hrdata_d = {16'h0000, out_q};
            else if (word_addr(haddr) == pad_ctrl_pkg::ALT_ADDR)
                hrdata_d = {16'h0000, alt_q};
            else
                hrdata_d = 32'h0000_0000;
        end
    end

    // reset returns all pins to input and tristates them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dir_q <= pad_ctrl_pkg::DIR_RESET;
            out_q <= pad_ctrl_pkg::OUT_RESET;
            alt_q <= pad_ctrl_pkg::ALT_RESET;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 10'h000;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            dir_q <= dir_d;
            out_q <= out_d;
            alt_q <= alt_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
        end
    end

    // status mode flag; only pins 1 and 2 are taken over
    assign alt_en = alt_q[pad_ctrl_pkg::ALT_EN_BIT];

    // pad strength and pull-up fields go straight from flops to the pad ring
    always_comb
    begin
        low_pins_drive_strength = dir_q[pad_ctrl_pkg::DIR_DRV_LSB +: 2];
        high_pins_drive_strength = out_q[pad_ctrl_pkg::OUT_HI_DRV_LSB +: 2];
        serial_out_drive_strength = out_q[pad_ctrl_pkg::OUT_SDO_DRV_LSB +: 2];
        clock_out_drive_strength = out_q[pad_ctrl_pkg::OUT_CLKO_DRV_LSB +: 2];
        irq_drive_strength = out_q[pad_ctrl_pkg::OUT_IRQ_DRV_LSB +: 2];
        // pull-up off leaves the line open drain; the board must supply one
        irq_pullup_enable = out_q[pad_ctrl_pkg::OUT_PUP_BIT];
    end

    // alt mode forces pins 1 and 2 to driven status outputs
    always_comb
    begin
        pin_oe_en = dir_q[pad_ctrl_pkg::DIR_OEN_LSB +: 7];
        pin_ien = dir_q[pad_ctrl_pkg::DIR_IEN_LSB +: 7];
        pin_lvl = out_q[pad_ctrl_pkg::OUT_LVL_LSB +: 7];
        if (alt_en)
        begin
            pin_oe_en[1:0] = 2'h3;
            pin_ien[1:0] = 2'h0;
            pin_lvl[1:0] = {crc_cca_valid, radio_out_of_idle};
        end
    end

    // one pad cell per pin; the cell owns its input capture flop
    genvar g;
    generate
        for (g = 0; g < pad_ctrl_pkg::NUM_PINS; g = g + 1)
        begin : g_pin
            pin_pad u_pad (
                .hclk(hclk),
                .hresetn(hresetn),
                .out_en(pin_oe_en[g]),
                .in_en(pin_ien[g]),
                .level(pin_lvl[g]),
                .pad_i(pin_i[g]),
                .pad_o(pin_o[g]),
                .pad_oe(pin_oe[g]),
                .pad_in_q(pin_in_level[g])
            );
            // each pad on its own: both enables set leaves it undriven
            pad_input_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
                pin_oe_en[g] && pin_ien[g] |-> !pin_oe[g] && !pin_o[g])
                else $error("pad driven with input enabled");
            pad_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
                pin_oe_en[g] && !pin_ien[g] |-> pin_oe[g] && pin_o[g] == pin_lvl[g])
                else $error("pad level differs from register");
        end
    endgenerate

    // whole-port checks on the pins and the register bus
    input_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pin_oe & dir_q[6:0] & ~{5'h00, {2{alt_en}}}) == 7'h00)
        else $error("pin driven while input enabled");
    undriven_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (pin_o & ~pin_oe) == 7'h00)
        else $error("level on undriven pin");
    dir_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_addr_q == pad_ctrl_pkg::DIR_ADDR |=> dir_q == $past(hwdata[15:0]))
        else $error("direction write lost");
    out_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_addr_q == pad_ctrl_pkg::OUT_ADDR |=> out_q == $past(hwdata[15:0]))
        else $error("output write lost");
    drive_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !alt_en |-> (pin_o == (dir_q[13:7] & ~dir_q[6:0] & out_q[6:0])))
        else $error("pin level mismatch");
    alt_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
        alt_en |-> pin_oe[1:0] == 2'h3 && pin_o[0] == radio_out_of_idle
            && pin_o[1] == crc_cca_valid)
        else $error("alt status pins wrong");
    strength_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_drive_strength == out_q[9:8] && low_pins_drive_strength == dir_q[15:14])
        else $error("drive strength mismatch");
    read_back_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && word_addr(haddr) == pad_ctrl_pkg::OUT_ADDR && !wr_pend_q
        |=> hrdata == {16'h0000, $past(out_q)})
        else $error("read data wrong");
    after_reset_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> pin_oe == 7'h00 && irq_pullup_enable)
        else $error("pins not tristated after reset");

    // pads after a reset release: levels low, strengths at their reset codes
    reset_pads_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> pin_o == 7'h00 && irq_drive_strength == 2'h3
            && low_pins_drive_strength == 2'h0 && high_pins_drive_strength == 2'h0
            && serial_out_drive_strength == 2'h0 && clock_out_drive_strength == 2'h0)
        else $error("pad state wrong after reset");
    reset_dir_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> pin_oe == 7'h00 && pin_in_level == 7'h00
            && hrdata == 32'h0000_0000)
        else $error("direction state wrong after reset");

    // output enables follow the direction register outside the status mode
    oe_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !alt_en
        |-> pin_oe == (dir_q[13:7] & ~dir_q[6:0]))
        else $error("output enable map wrong");
    // pins neither enabled stay quiet whatever their level bits say
    quiet_pins_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !alt_en && dir_q[13:7] == 7'h00
        |-> pin_oe == 7'h00 && pin_o == 7'h00)
        else $error("disabled pins not quiet");
    alt_others_a: assert property (@(posedge hclk) disable iff (!hresetn)
        alt_en
        |-> pin_oe[6:2] == (dir_q[13:9] & ~dir_q[6:2]))
        else $error("status mode touched pins 3 to 7");

    // input capture; the reset term keeps the release edge out, when the
    // flops are still held and see nothing of the pin
    in_sample_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && !alt_en && dir_q[6:0] == 7'h7F
        |=> pin_in_level == $past(pin_i))
        else $error("input sample lost");
    // a pin with input off keeps its last sample
    in_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && !alt_en && dir_q[6:0] == 7'h00
        |=> $stable(pin_in_level))
        else $error("disabled input moved");
    // status pins never sample their pads
    alt_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && alt_en
        |=> $stable(pin_in_level[1:0]))
        else $error("status pins captured input");

    // a write reaches the pad ring one cycle after its data phase
    low_drv_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_addr_q == pad_ctrl_pkg::DIR_ADDR
        |=> low_pins_drive_strength == $past(hwdata[15:14]))
        else $error("low pin strength write lost");
    high_drv_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_addr_q == pad_ctrl_pkg::OUT_ADDR
        |=> high_pins_drive_strength == $past(hwdata[15:14]))
        else $error("high pin strength write lost");
    pad_drv_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_addr_q == pad_ctrl_pkg::OUT_ADDR
        |=> serial_out_drive_strength == $past(hwdata[13:12])
            && clock_out_drive_strength == $past(hwdata[11:10]))
        else $error("pad strength write lost");
    irq_cfg_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_addr_q == pad_ctrl_pkg::OUT_ADDR
        |=> irq_drive_strength == $past(hwdata[9:8])
            && irq_pullup_enable == $past(hwdata[7]))
        else $error("request pad setting lost");
    level_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_addr_q == pad_ctrl_pkg::OUT_ADDR && !alt_en
        |=> pin_o == ($past(hwdata[6:0]) & dir_q[13:7] & ~dir_q[6:0]))
        else $error("level write not on pins");

    // reads of the other words, and writes that hit nothing
    read_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && word_addr(haddr) == pad_ctrl_pkg::DIR_ADDR && !wr_pend_q
        |=> hrdata == {16'h0000, $past(dir_q)})
        else $error("direction read wrong");
    read_unmapped_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && word_addr(haddr) != pad_ctrl_pkg::DIR_ADDR
            && word_addr(haddr) != pad_ctrl_pkg::OUT_ADDR
            && word_addr(haddr) != pad_ctrl_pkg::ALT_ADDR
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    stray_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q && wr_addr_q != pad_ctrl_pkg::DIR_ADDR
            && wr_addr_q != pad_ctrl_pkg::OUT_ADDR && wr_addr_q != pad_ctrl_pkg::ALT_ADDR
        |=> $stable(dir_q) && $stable(out_q) && $stable(alt_q))
        else $error("unmapped write changed a register");
endmodule : gpio_pad_control

// ---- core/pad_ctrl_pkg.sv ----
// register map, field layout and reset values of the pad control block
package pad_ctrl_pkg;
    // printed register numbers are indices; byte address is four times the index
    localparam logic [7:0] DIR_INDEX = 8'h0B;
    localparam logic [7:0] OUT_INDEX = 8'h0C;
    localparam logic [7:0] ALT_INDEX = 8'h09;
    localparam logic [9:0] DIR_ADDR = {DIR_INDEX, 2'b00};
    localparam logic [9:0] OUT_ADDR = {OUT_INDEX, 2'b00};
    localparam logic [9:0] ALT_ADDR = {ALT_INDEX, 2'b00};
    localparam int NUM_PINS = 7;
    // direction register fields
    localparam int DIR_IEN_LSB = 0;
    localparam int DIR_OEN_LSB = 7;
    localparam int DIR_DRV_LSB = 14;
    // output register fields
    localparam int OUT_LVL_LSB = 0;
    localparam int OUT_PUP_BIT = 7;
    localparam int OUT_IRQ_DRV_LSB = 8;
    localparam int OUT_CLKO_DRV_LSB = 10;
    localparam int OUT_SDO_DRV_LSB = 12;
    localparam int OUT_HI_DRV_LSB = 14;
    // alternative interface control
    localparam int ALT_EN_BIT = 7;
    // reset values, then bus transfer codes
    localparam logic [15:0] DIR_RESET = 16'h007F;
    localparam logic [15:0] OUT_RESET = 16'h0380;
    localparam logic [15:0] ALT_RESET = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : pad_ctrl_pkg

// ---- core/pin_pad.sv ----
// one general-purpose pin: output gating and input capture
`timescale 1ns/1ps
module pin_pad (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic out_en,
    input wire logic in_en,
    input wire logic level,
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe,
    output logic pad_in_q
);
    logic pad_in_d;

    // input wins when both enables are set; undriven pad ignores level
    always_comb
    begin
        pad_oe = out_en & ~in_en;
        pad_o = pad_oe & level;
        pad_in_d = in_en ? pad_i : pad_in_q;
    end

    // inputs are synchronous; a disabled input holds its last sample
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pad_in_q <= 1'b0;
        else
            pad_in_q <= pad_in_d;
    end
endmodule : pin_pad

// ---- tb/pin_partner.sv ----
// external devices on the seven pins and the board pull-up of the request line
`timescale 1ns/1ps
module pin_partner (
    input wire logic [6:0] pin_o,
    input wire logic [6:0] pin_oe,
    input wire logic [6:0] ext_level,
    output logic [6:0] pin_i,
    output logic irq_line
);
    // wire level: the block's driver where enabled, the outside device elsewhere
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_level);
    // board pull-up keeps the line high even with the on-chip one off
    assign irq_line = 1'b1;
endmodule : pin_partner

// ---- tb/tb.sv ----
// self-checking bench of the pad control block over its register bus
`timescale 1ns/1ps
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, busy_st = 1'b0, crc_st = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hreadyout, hresp, irq_pullup_enable, irq_line;
    logic [6:0] pin_i, pin_o, pin_oe, pin_in_level, ext = 7'h00;
    logic [1:0] low_pins_drive_strength, high_pins_drive_strength, serial_out_drive_strength;
    logic [1:0] clock_out_drive_strength, irq_drive_strength;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    gpio_pad_control u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .radio_out_of_idle(busy_st),
        .crc_cca_valid(crc_st), .pin_i, .pin_o, .pin_oe, .pin_in_level,
        .low_pins_drive_strength, .high_pins_drive_strength, .serial_out_drive_strength,
        .clock_out_drive_strength, .irq_drive_strength, .irq_pullup_enable);
    pin_partner u_far (.pin_o, .pin_oe, .ext_level(ext), .pin_i, .irq_line(irq_line));

    // 40 ns period
    always #20 hclk = ~hclk;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // the run needs about 70 cycles; a hang is cut well past that
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one single transfer: address phase, then data phase; read data taken at its end
    task automatic xfer(input logic [9:0] a, input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= pad_ctrl_pkg::HTRANS_NONSEQ;
        haddr <= {22'h0, a};
        hwrite <= wr;
        hsize <= pad_ctrl_pkg::HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
        #1;
    endtask : xfer

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk("oe", 32'h0, {25'h0, pin_oe});
        chk("irqdrv", 32'h3, {30'h0, irq_drive_strength});
        chk("pup", 32'h1, {31'h0, irq_pullup_enable});
        xfer(pad_ctrl_pkg::DIR_ADDR, 1'b0, 32'h0);
        chk("dir", 32'h007F, rd);
        xfer(pad_ctrl_pkg::OUT_ADDR, 1'b0, 32'h0);
        chk("out", 32'h0380, rd);
        chk("lodrv", 32'h0, {30'h0, low_pins_drive_strength});
        $display("test reset done");
        // upper half of the write word must be dropped
        xfer(pad_ctrl_pkg::DIR_ADDR, 1'b1, 32'hABCDFF80);
        xfer(pad_ctrl_pkg::OUT_ADDR, 1'b1, 32'h00005555);
        chk("oe", 32'h7F, {25'h0, pin_oe});
        chk("lvl", 32'h55, {25'h0, pin_o});
        chk("lodrv", 32'h3, {30'h0, low_pins_drive_strength});
        chk("hidrv", 32'h1, {30'h0, high_pins_drive_strength});
        chk("sdodrv", 32'h1, {30'h0, serial_out_drive_strength});
        chk("clkdrv", 32'h1, {30'h0, clock_out_drive_strength});
        chk("irqdrv", 32'h1, {30'h0, irq_drive_strength});
        chk("pup", 32'h0, {31'h0, irq_pullup_enable});
        chk("irqline", 32'h1, {31'h0, irq_line});
        xfer(pad_ctrl_pkg::DIR_ADDR, 1'b0, 32'h0);
        chk("dir", 32'hFF80, rd);
        xfer(pad_ctrl_pkg::OUT_ADDR, 1'b0, 32'h0);
        chk("out", 32'h5555, rd);
        $display("test outputs done");
        xfer(pad_ctrl_pkg::DIR_ADDR, 1'b1, 32'h3FFF);
        chk("oe", 32'h0, {25'h0, pin_oe});
        @(posedge hclk);
        ext <= 7'h2A;
        repeat (2) @(posedge hclk);
        #1;
        chk("inlvl", 32'h2A, {25'h0, pin_in_level});
        xfer(pad_ctrl_pkg::DIR_ADDR, 1'b1, 32'h0000);
        chk("oe", 32'h0, {25'h0, pin_oe});
        chk("lvl", 32'h0, {25'h0, pin_o});
        xfer(10'h100, 1'b1, 32'h0000FFFF);
        xfer(10'h100, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd);
        xfer(pad_ctrl_pkg::DIR_ADDR, 1'b0, 32'h0);
        chk("dir", 32'h0, rd);
        $display("test direction done");
        xfer(pad_ctrl_pkg::DIR_ADDR, 1'b1, 32'h0180);
        xfer(pad_ctrl_pkg::OUT_ADDR, 1'b1, 32'h0002);
        xfer(pad_ctrl_pkg::ALT_ADDR, 1'b1, 32'h0080);
        @(posedge hclk);
        busy_st <= 1'b1;
        @(posedge hclk);
        #1;
        chk("alt", 32'h1, {30'h0, pin_o[1:0]});
        chk("altoe", 32'h3, {30'h0, pin_oe[1:0]});
        @(posedge hclk);
        crc_st <= 1'b1;
        @(posedge hclk);
        #1;
        chk("alt", 32'h3, {30'h0, pin_o[1:0]});
        $display("test status pins done");
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1;
        chk("oe", 32'h0, {25'h0, pin_oe});
        @(posedge hclk);
        hresetn <= 1'b1;
        xfer(pad_ctrl_pkg::DIR_ADDR, 1'b0, 32'h0);
        chk("dir", 32'h007F, rd);
        $display("test second reset done");
        give_verdict();
    end
endmodule : tb
